// *** verilog/tdc_defs.svh ***
`ifndef TDC_DEFS_SVH
`define TDC_DEFS_SVH

// register byte offsets
`define TDC_SYNTH_STEP_OFS   8'h04
`define TDC_SYNTH_INC_OFS    8'h08
`define TDC_DI_CFG_OFS       8'h0c
`define TDC_SYNC_STAT_OFS    8'h10
`define TDC_INC_VAR_OFS      8'h14
`define TDC_ROLE_CFG_OFS     8'h18
`define TDC_CMD_CTRL_OFS     8'h20
`define TDC_CMD_TIME_OFS     8'h24
`define TDC_DAT_BASE_OFS     8'h44
`define TDC_TIMESTAMP_TIMECODE_COMPARE_OFS         8'h80
`define TDC_LAT0_OFS         8'ha4
`define TDC_LAT1_OFS         8'ha8

// synthesizer and elapsed time
`define TDC_SYNTH_W          30
`define TDC_ESTEP_W          8
`define TDC_ELAPSED_W        40
`define TDC_TC_LSB           8

// distributed interrupt config fields
`define TDC_MASK_LSB         16
`define TDC_MASK_W           6
`define TDC_RECEIVED_INTERRUPT_MSB_BIT        13
`define TDC_TRANSMITTED_INTERRUPT_MSB_BIT        12
`define TDC_WIDE_INTERRUPT_ENABLE_BIT         11
`define TDC_ACK_BIT          10
`define TDC_RECEIVED_INTERRUPT_NUMBER_LSB         5
`define TDC_TRANSMITTED_INTERRUPT_NUMBER_LSB         0
`define TDC_DINUM_W          5
`define TDC_DI_CFG_WMASK     32'h003f3c1f

// sync status fields
`define TDC_MA_BIT           31
`define TDC_EDS_LSB          24
`define TDC_FW_LSB           16
`define TDC_CW_LSB           8
`define TDC_ARM_BIT          3
`define TDC_LC_BIT           2
`define TDC_TCQ_BIT          1
`define TDC_SYNCHRONISED_FLAG_BIT       0
`define TDC_MA_VALUE         1'b0

// command control fields
`define TDC_NC_BIT           31
`define TDC_IS_BIT           30
`define TDC_CTC_LSB          16
`define TDC_CTRL_WMASK       32'hc0ffffff

// role config fields
`define TDC_INIT_BIT         0
`define TDC_TGT_BIT          1
`define TDC_XLD_EN_BIT       2
`define TDC_XLD_RISE_BIT     3

`define TDC_DAT_CH           4
`define TDC_RESET_WORD       32'h00000000

`endif

// *** verilog/tdc_pkg.sv ***
`default_nettype none

package tdc_pkg;
	typedef logic [31:0] tdc_word_t;
	typedef logic [7:0]  tdc_addr_t;
	typedef logic [7:0]  tdc_tcode_t;
	typedef logic [5:0]  tdc_dinum_t;
endpackage

`default_nettype wire

// *** verilog/tdc_pin_sync.sv ***
`default_nettype none

module tdc_pin_sync #(
	parameter int W = 1
) (
	input  wire logic         mclk,
	input  wire logic         nrst,
	input  wire logic [W-1:0] pin,
	output logic      [W-1:0] level_q
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// a change counts only once stages two and three agree
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge mclk or negedge nrst) begin
				if (!nrst)
					level_q[i] <= 1'b0;
				else if (s2_q[i] == s3_q[i])
					level_q[i] <= s3_q[i];
			end
		end
	endgenerate
endmodule

`default_nettype wire

// *** verilog/tdc_core.sv ***
`default_nettype none
`include "tdc_defs.svh"

// Functional notes
// - add elapsed_step on each synthesizer wrap
// - add synth_step to accumulator every clock
// - initiator compares time-code under match mask
// - timestamp_timecode_compare selects trigger time-code
// - received_interrupt_msb tops received number
// - transmitted_interrupt_msb tops transmitted number
// - wide mode allows all 64 interrupt numbers in interrupt-only mode
// - ack_mode_select picks acknowledge or interrupt-only
// - record last received interrupt number
// - hold transmitted interrupt number
// - datation flag sets on pin rising edge, read clears
// - report fine and coarse widths from preamble
// - armed flag set by write, cleared by load
// - external edge loads elapsed from command value
// - latency write sets flag in target role only, software clears
// - flag qualified time message on matching code
// - flag in-sync after init or external load; sync only once already in-sync
// - init_or_sync_select picks init or sync
// - initiator time message on command_timecode match
// - target qualifies on command_timecode match
// - preamble gives coarse and fine octet counts
// - command_time_word0 supplies elapsed bits 0..31
// - mitigation_present reads as zero
module tdc_core
	import tdc_pkg::*;
(
	input  wire logic            mclk,
	input  wire logic            nrst,
	input  wire tdc_addr_t       reg_addr,
	input  wire tdc_word_t       reg_wdata,
	input  wire logic            reg_wr,
	input  wire logic            reg_rd,
	output tdc_word_t            reg_rdata_q,
	input  wire logic            ext_load_pin,
	input  wire logic [3:0]      ext_dat_pin,
	input  wire logic            tc_rx_valid,
	input  wire tdc_tcode_t      tc_rx_value,
	input  wire logic            di_rx_valid,
	input  wire tdc_dinum_t      di_rx_number,
	output logic                 tc_tx_valid_q,
	output tdc_tcode_t           tc_tx_value_q,
	output logic                 tm_event_q,
	output logic                 di_tx_valid_q,
	output tdc_dinum_t           di_tx_number_q,
	output logic                 di_ack_valid_q,
	output tdc_dinum_t           di_ack_number_q
);

	////////////////////////////////////////////////////////////////////
	// registers

	logic [`TDC_SYNTH_W-1:0]   synth_step_q;
	logic [`TDC_ESTEP_W-1:0]   elapsed_step_q;
	tdc_word_t                 di_cfg_q;
	tdc_word_t                 role_cfg_q;
	tdc_word_t                 cmd_ctrl_q;
	tdc_word_t                 cmd_time_q;
	tdc_tcode_t                timestamp_timecode_compare_q;
	tdc_word_t                 lat0_q;
	tdc_word_t                 lat1_q;
	logic [`TDC_SYNTH_W-1:0]   acc_q;
	logic [`TDC_ELAPSED_W-1:0] elapsed_q;
	logic                      armed_q;
	logic                      lc_q;
	logic                      tcq_q;
	logic                      synchronised_flag_q;
	logic [3:0]                eds_q;
	tdc_word_t                 dat_q [`TDC_DAT_CH];
	tdc_tcode_t                tc_prev_q;
	logic                      xld_prev_q;
	logic [3:0]                dat_prev_q;
	logic [5:0]                coarse_w_q;
	logic [6:0]                fine_w_q;

	////////////////////////////////////////////////////////////////////
	// pin synchronisers

	logic       xld_lvl;
	logic [3:0] dat_lvl;

	tdc_pin_sync #(.W(5)) u_sync (
		.mclk    (mclk),
		.nrst    (nrst),
		.pin     ({ext_load_pin, ext_dat_pin}),
		.level_q ({xld_lvl, dat_lvl})
	);

	////////////////////////////////////////////////////////////////////
	// decode

	wire is_init   = role_cfg_q[`TDC_INIT_BIT];
	wire is_tgt    = role_cfg_q[`TDC_TGT_BIT];
	wire xld_en    = role_cfg_q[`TDC_XLD_EN_BIT];
	wire xld_rise  = role_cfg_q[`TDC_XLD_RISE_BIT];
	wire ack_mode  = di_cfg_q[`TDC_ACK_BIT];
	wire wide_en   = di_cfg_q[`TDC_WIDE_INTERRUPT_ENABLE_BIT];
	wire wide_ok   = wide_en & ~ack_mode;
	wire new_cmd   = cmd_ctrl_q[`TDC_NC_BIT];
	wire init_sel  = cmd_ctrl_q[`TDC_IS_BIT];
	wire [7:0] cmd_tc = cmd_ctrl_q[`TDC_CTC_LSB +: 8];
	// preamble as written; widths latch with the write
	wire [15:0] command_preamble   = reg_wdata[15:0];

	wire wr_synth  = reg_wr && reg_addr == `TDC_SYNTH_STEP_OFS;
	wire wr_inc    = reg_wr && reg_addr == `TDC_SYNTH_INC_OFS;
	wire wr_dicfg  = reg_wr && reg_addr == `TDC_DI_CFG_OFS;
	wire wr_stat   = reg_wr && reg_addr == `TDC_SYNC_STAT_OFS;
	wire wr_role   = reg_wr && reg_addr == `TDC_ROLE_CFG_OFS;
	wire wr_ctrl   = reg_wr && reg_addr == `TDC_CMD_CTRL_OFS;
	wire wr_time   = reg_wr && reg_addr == `TDC_CMD_TIME_OFS;
	wire wr_timestamp_timecode_compare   = reg_wr && reg_addr == `TDC_TIMESTAMP_TIMECODE_COMPARE_OFS;
	wire wr_lat0   = reg_wr && reg_addr == `TDC_LAT0_OFS;
	wire wr_lat1   = reg_wr && reg_addr == `TDC_LAT1_OFS;

	// synthesizer: carry out of the accumulator is the wrap
	wire [`TDC_SYNTH_W:0] acc_sum = {1'b0, acc_q} + {1'b0, synth_step_q};
	wire synth_wrap = acc_sum[`TDC_SYNTH_W];

	// internal time-code follows the elapsed counter
	wire [7:0] tc_int = elapsed_q[`TDC_TC_LSB +: 8];
	wire tc_new = is_init && tc_int != tc_prev_q;
	wire [`TDC_MASK_W-1:0] timecode_match_mask = di_cfg_q[`TDC_MASK_LSB +: `TDC_MASK_W];
	wire tc_hit = ((tc_int[`TDC_MASK_W-1:0] ^ timestamp_timecode_compare_q[`TDC_MASK_W-1:0])
		& timecode_match_mask) == '0;
	wire tm_hit = tc_new && tc_int == cmd_tc;

	// target: qualify received code against command time-code
	wire rx_qual = is_tgt && tc_rx_valid && tc_rx_value == cmd_tc;
	wire rx_take = rx_qual && new_cmd;

	// external load on the chosen edge
	wire xld_edge = xld_rise ? (xld_lvl & ~xld_prev_q)
		: (~xld_lvl & xld_prev_q);
	wire xld_take = xld_en && armed_q && xld_edge;

	// preamble: coarse octets 1+b11:10 (+b6:5), fine b9:8 (+b4:2)
	wire [2:0] coarse_oct = 3'(command_preamble[11:10]) + 3'd1 + 3'(command_preamble[6:5]);
	wire [3:0] fine_oct   = 4'(command_preamble[9:8]) + 4'(command_preamble[4:2]);
	wire [5:0] coarse_w   = {coarse_oct, 3'b000};
	wire [6:0] fine_w     = {fine_oct, 3'b000};

	// transmitted and received interrupt numbers
	wire tx_msb = wide_ok & di_cfg_q[`TDC_TRANSMITTED_INTERRUPT_MSB_BIT];
	wire [5:0] tx_num = {tx_msb,
		di_cfg_q[`TDC_TRANSMITTED_INTERRUPT_NUMBER_LSB +: `TDC_DINUM_W]};
	wire rx_msb = wide_ok ? di_rx_number[5]
		: di_cfg_q[`TDC_RECEIVED_INTERRUPT_MSB_BIT];

	////////////////////////////////////////////////////////////////////
	// read mux

	wire [3:0] dat_rd;
	wire tdc_word_t stat_word = {`TDC_MA_VALUE, 3'b000, eds_q, 1'b0,
		fine_w_q, 2'b00, coarse_w_q, 4'h0, armed_q, lc_q, tcq_q,
		synchronised_flag_q};
	wire [1:0] dat_idx = 2'((reg_addr - `TDC_DAT_BASE_OFS) >> 2);
	wire in_dat = reg_addr >= `TDC_DAT_BASE_OFS
		&& reg_addr < `TDC_DAT_BASE_OFS + 8'h10
		&& reg_addr[1:0] == 2'b00;

	// unmapped and unusable locations read zero
	wire tdc_word_t rd_word =
		reg_addr == `TDC_SYNTH_STEP_OFS ? {2'b00, synth_step_q} :
		reg_addr == `TDC_SYNTH_INC_OFS ? {24'h0, elapsed_step_q} :
		reg_addr == `TDC_DI_CFG_OFS ? di_cfg_q :
		reg_addr == `TDC_SYNC_STAT_OFS ? stat_word :
		reg_addr == `TDC_ROLE_CFG_OFS ? role_cfg_q :
		reg_addr == `TDC_CMD_CTRL_OFS ? cmd_ctrl_q :
		reg_addr == `TDC_CMD_TIME_OFS ? cmd_time_q :
		reg_addr == `TDC_TIMESTAMP_TIMECODE_COMPARE_OFS ? {timestamp_timecode_compare_q, 24'h0} :
		reg_addr == `TDC_LAT0_OFS ? lat0_q :
		reg_addr == `TDC_LAT1_OFS ? lat1_q :
		in_dat ? dat_q[dat_idx] : `TDC_RESET_WORD;

	////////////////////////////////////////////////////////////////////
	// software registers

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			synth_step_q   <= '0;
			elapsed_step_q <= '0;
			role_cfg_q     <= '0;
			timestamp_timecode_compare_q         <= '0;
			lat0_q         <= '0;
			lat1_q         <= '0;
			cmd_time_q     <= '0;
			reg_rdata_q    <= '0;
		end else begin
			if (wr_synth)
				synth_step_q <= reg_wdata[`TDC_SYNTH_W-1:0];
			// compensation bits are dropped, they have no effect
			if (wr_inc)
				elapsed_step_q <= reg_wdata[`TDC_ESTEP_W-1:0];
			if (wr_role)
				role_cfg_q <= {28'h0, reg_wdata[3:0]};
			if (wr_timestamp_timecode_compare)
				timestamp_timecode_compare_q <= reg_wdata[31:24];
			if (wr_lat0)
				lat0_q <= reg_wdata;
			if (wr_lat1)
				lat1_q <= reg_wdata;
			if (wr_time)
				cmd_time_q <= reg_wdata;
			reg_rdata_q <= reg_rd ? rd_word : '0;
		end
	end

	// interrupt config: hardware updates the received number
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst)
			di_cfg_q <= '0;
		else if (di_rx_valid) begin
			di_cfg_q[`TDC_RECEIVED_INTERRUPT_NUMBER_LSB +: `TDC_DINUM_W] <= di_rx_number[4:0];
			di_cfg_q[`TDC_RECEIVED_INTERRUPT_MSB_BIT] <= rx_msb;
		end else if (wr_dicfg)
			di_cfg_q <= reg_wdata & `TDC_DI_CFG_WMASK;
	end

	// new command is consumed by a qualified receive
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst)
			cmd_ctrl_q <= '0;
		else if (wr_ctrl)
			cmd_ctrl_q <= reg_wdata & `TDC_CTRL_WMASK;
		else if (rx_take)
			cmd_ctrl_q[`TDC_NC_BIT] <= 1'b0;
	end

	// widths held, not decoded live: a zero preamble
	// would report one coarse octet and break the zero reset value
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			coarse_w_q <= '0;
			fine_w_q   <= '0;
		end else if (wr_ctrl) begin
			coarse_w_q <= coarse_w;
			fine_w_q   <= fine_w;
		end
	end

	////////////////////////////////////////////////////////////////////
	// synthesizer and elapsed counter

	// external load beats a received message, both beat stepping
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			acc_q     <= '0;
			elapsed_q <= '0;
		end else begin
			acc_q <= acc_sum[`TDC_SYNTH_W-1:0];
			if (xld_take)
				elapsed_q <= {8'h00, cmd_time_q};
			else if (rx_take)
				elapsed_q <= {8'h00, cmd_time_q};
			else if (synth_wrap)
				elapsed_q <= elapsed_q + `TDC_ELAPSED_W'(elapsed_step_q);
		end
	end

	////////////////////////////////////////////////////////////////////
	// status flags, set wins over clear

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			armed_q    <= 1'b0;
			lc_q       <= 1'b0;
			tcq_q      <= 1'b0;
			synchronised_flag_q   <= 1'b0;
			xld_prev_q <= 1'b0;
		end else begin
			xld_prev_q <= xld_lvl;
			if (wr_time && xld_en)
				armed_q <= 1'b1;
			else if (xld_take)
				armed_q <= 1'b0;
			if (is_tgt && (wr_lat0 || wr_lat1))
				lc_q <= 1'b1;
			else if (wr_stat && reg_wdata[`TDC_LC_BIT])
				lc_q <= 1'b0;
			if (rx_qual)
				tcq_q <= 1'b1;
			// sync only counts once the flag is already set, by a prior init or an external load
			if (rx_take && (init_sel || synchronised_flag_q))
				synchronised_flag_q <= 1'b1;
			else if (xld_take)
				synchronised_flag_q <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// external datation channels

	genvar ch;
	generate
		for (ch = 0; ch < `TDC_DAT_CH; ch++) begin : g_dat
			wire hit = dat_lvl[ch] & ~dat_prev_q[ch];
			wire rd  = reg_rd && in_dat && dat_idx == 2'(ch);
			assign dat_rd[ch] = rd;
			always_ff @(posedge mclk or negedge nrst) begin
				if (!nrst) begin
					eds_q[ch]      <= 1'b0;
					dat_q[ch]      <= '0;
					dat_prev_q[ch] <= 1'b0;
				end else begin
					dat_prev_q[ch] <= dat_lvl[ch];
					if (hit) begin
						eds_q[ch] <= 1'b1;
						dat_q[ch] <= elapsed_q[31:0];
					end else if (dat_rd[ch])
						eds_q[ch] <= 1'b0;
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// link outputs

	// four channel words, each read clears only its own channel's flag
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			tc_prev_q       <= '0;
			tc_tx_valid_q   <= 1'b0;
			tc_tx_value_q   <= '0;
			tm_event_q      <= 1'b0;
			di_tx_valid_q   <= 1'b0;
			di_tx_number_q  <= '0;
			di_ack_valid_q  <= 1'b0;
			di_ack_number_q <= '0;
		end else begin
			tc_prev_q     <= tc_int;
			tc_tx_valid_q <= tc_new;
			tc_tx_value_q <= tc_int;
			tm_event_q    <= tm_hit;
			di_tx_valid_q <= tc_new && tc_hit;
			di_tx_number_q <= tx_num;
			di_ack_valid_q <= is_tgt && ack_mode && di_rx_valid;
			di_ack_number_q <= di_rx_number;
		end
	end

endmodule

`default_nettype wire

// *** bench/tdc_core_sva.sv ***
`default_nettype none

module tdc_core_chk
	import tdc_pkg::*;
(
	input wire logic       mclk,
	input wire logic       nrst,
	input wire tdc_addr_t  reg_addr,
	input wire logic       reg_rd,
	input wire tdc_word_t  reg_rdata_q,
	input wire logic       di_rx_valid,
	input wire tdc_dinum_t di_rx_number,
	input wire logic       tc_tx_valid_q,
	input wire logic       tm_event_q,
	input wire logic       di_tx_valid_q,
	input wire logic       di_ack_valid_q,
	input wire tdc_dinum_t di_ack_number_q
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	a_rdata_idle: assert property (!reg_rd |=> reg_rdata_q == 32'h0)
		else $error("read data not zero");
	a_ack_cause: assert property (di_ack_valid_q |-> $past(di_rx_valid))
		else $error("ack without interrupt");
	a_ack_number: assert property (di_ack_valid_q |->
		di_ack_number_q == $past(di_rx_number)) else $error("ack number");
	a_tm_pulse: assert property (tm_event_q |=> !tm_event_q)
		else $error("time message event too long");
	a_tm_code: assert property (tm_event_q |-> tc_tx_valid_q)
		else $error("time message off a code change");
	a_di_on_code: assert property (di_tx_valid_q |-> tc_tx_valid_q)
		else $error("interrupt off a code change");
	a_unmapped_zero: assert property (reg_rd && reg_addr == 8'hfc |=>
		reg_rdata_q == 32'h0) else $error("unmapped read not zero");
	a_incvar_zero: assert property (reg_rd && reg_addr == 8'h14 |=>
		reg_rdata_q == 32'h0) else $error("variation read not zero");
	a_status_rsvd: assert property (reg_rd && reg_addr == 8'h10 |=>
		(reg_rdata_q & 32'hf080c0f0) == 32'h0) else $error("status bits");
	a_dicfg_rsvd: assert property (reg_rd && reg_addr == 8'h0c |=>
		(reg_rdata_q & 32'hffc0c000) == 32'h0) else $error("config bits");

	c_ack: cover property (di_ack_valid_q);
	c_tm: cover property (tm_event_q);
	c_ditx: cover property (di_tx_valid_q);
endmodule

bind tdc_core tdc_core_chk u_chk (.mclk(mclk), .nrst(nrst),
	.reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
	.di_rx_valid(di_rx_valid), .di_rx_number(di_rx_number),
	.tc_tx_valid_q(tc_tx_valid_q), .tm_event_q(tm_event_q),
	.di_tx_valid_q(di_tx_valid_q), .di_ack_valid_q(di_ack_valid_q),
	.di_ack_number_q(di_ack_number_q));

`default_nettype wire

// *** bench/tdc_router_model.sv ***
`default_nettype none

module tdc_router_model
	import tdc_pkg::*;
(
	input  wire logic  mclk,
	output logic       tc_rx_valid,
	output tdc_tcode_t tc_rx_value,
	output logic       di_rx_valid,
	output tdc_dinum_t di_rx_number
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		tc_rx_valid = 1'b0;
		tc_rx_value = 8'h00;
		di_rx_valid = 1'b0;
		di_rx_number = 6'h00;
	end

	// gap models a slow link; released lines show the inverse, not stale data
	task automatic send_tc(input tdc_tcode_t v, input int gap);
		repeat (gap) @(posedge mclk);
		@(posedge mclk);
		tc_rx_value <= v;
		tc_rx_valid <= 1'b1;
		@(posedge mclk);
		tc_rx_valid <= 1'b0;
		tc_rx_value <= ~v;
	endtask

	task automatic send_di(input tdc_dinum_t v, input int gap);
		repeat (gap) @(posedge mclk);
		@(posedge mclk);
		di_rx_number <= v;
		di_rx_valid <= 1'b1;
		@(posedge mclk);
		di_rx_valid <= 1'b0;
		di_rx_number <= ~v;
	endtask
endmodule

`default_nettype wire

// *** bench/tdc_core_bench.sv ***
`default_nettype none

module tdc_core_bench
	import tdc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic       mclk = 1'b0;
	logic       nrst = 1'b0;
	tdc_addr_t  reg_addr = 8'h00;
	tdc_word_t  reg_wdata = 32'h0;
	logic       reg_wr = 1'b0;
	logic       reg_rd = 1'b0;
	logic       ext_load_pin = 1'b0;
	logic [3:0] ext_dat_pin = 4'h0;
	tdc_word_t  reg_rdata_q;
	logic       tc_rx_valid, di_rx_valid, tc_tx_valid_q, tm_event_q;
	logic       di_tx_valid_q, di_ack_valid_q;
	tdc_tcode_t tc_rx_value, tc_tx_value_q;
	tdc_dinum_t di_rx_number, di_tx_number_q, di_ack_number_q;
	tdc_addr_t  ra [6] = '{8'h08, 8'h0c, 8'h10, 8'h14, 8'h20, 8'h24};
	int         fail_count = 0;
	int         cmp_count = 0;
	int         seed = 32'h7f92;
	int         i, n;
	tdc_word_t  d, e;

	always #4 mclk = ~mclk;

	tdc_core DUT (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata_q(reg_rdata_q), .ext_load_pin(ext_load_pin),
		.ext_dat_pin(ext_dat_pin), .tc_rx_valid(tc_rx_valid),
		.tc_rx_value(tc_rx_value), .di_rx_valid(di_rx_valid),
		.di_rx_number(di_rx_number), .tc_tx_valid_q(tc_tx_valid_q),
		.tc_tx_value_q(tc_tx_value_q), .tm_event_q(tm_event_q),
		.di_tx_valid_q(di_tx_valid_q), .di_tx_number_q(di_tx_number_q),
		.di_ack_valid_q(di_ack_valid_q), .di_ack_number_q(di_ack_number_q));

	tdc_router_model rtr (.mclk(mclk), .tc_rx_valid(tc_rx_valid),
		.tc_rx_value(tc_rx_value), .di_rx_valid(di_rx_valid),
		.di_rx_number(di_rx_number));

	////////////////////////////////////////////////////////////////////////
	function automatic tdc_word_t wid(input logic [15:0] c);
		return {9'h0, 7'((c[9:8] + c[4:2]) * 8), 2'b0,
			6'((1 + c[11:10] + c[6:5]) * 8), 8'h0};
	endfunction

	function automatic logic ditx(input tdc_tcode_t v, input tdc_word_t c);
		return ((v[5:0] ^ c[29:24]) & c[21:16]) == 6'h0;
	endfunction

	task automatic close_out;
		if (fail_count == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic chk(input string s, input tdc_word_t x, input tdc_word_t g);
		cmp_count++;
		if (g !== x) begin
			fail_count++;
			$display("ERROR %s exp %h got %h", s, x, g);
		end
	endtask

	task automatic wr(input tdc_addr_t a, input tdc_word_t v);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask

	// masked read compare; data stands only in the cycle after the strobe
	task automatic rc(input tdc_addr_t a, input tdc_word_t m,
		input tdc_word_t x, input string s);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		chk(s, x, reg_rdata_q & m);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (10) @(posedge mclk);
		nrst <= 1'b1;
		foreach (ra[k]) rc(ra[k], 32'hffffffff, 32'h0, "reset");
		for (n = 0; n < 4; n++) begin
			d = $random(seed);
			wr(8'h08, d);
			rc(8'h08, 32'hff, d & 32'hff, "estep");
			wr(8'h14, d);
			rc(8'h14, 32'hffffffff, 32'h0, "incvar");
			rc(8'hfc, 32'hffffffff, 32'h0, "unmapped");
			wr(8'h24, d);
			rc(8'h24, 32'hffffffff, d, "cmdtime");
			wr(8'h20, d & 32'h3fffffff);
			rc(8'h20, 32'hffffffff, d & 32'h00ffffff, "ctrl");
			rc(8'h10, 32'h007f3f00, wid(d[15:0]), "widths");
			wr(8'h0c, d);
			rc(8'h0c, 32'hffffffff, d & 32'h003f3c1f, "dicfg");
		end
		wr(8'h18, 32'hc);
		e = $random(seed);
		wr(8'h24, e);
		rc(8'h10, 32'h9, 32'h8, "armed");
		@(posedge mclk);
		ext_load_pin <= 1'b1;
		repeat (8) @(posedge mclk);
		rc(8'h10, 32'h9, 32'h1, "loaded");
		wr(8'h18, 32'h2);
		wr(8'h20, 32'h80a50000);
		e = $random(seed);
		wr(8'h24, e);
		rtr.send_tc(8'h5a, 0);
		rc(8'h10, 32'h2, 32'h0, "tcq_miss");
		rtr.send_tc(8'ha5, 3);
		rc(8'h10, 32'h3, 32'h3, "tcq_hit");
		rc(8'h20, 32'hc0000000, 32'h0, "nc_clr");
		@(posedge mclk);
		ext_dat_pin <= 4'h5;
		repeat (8) @(posedge mclk);
		rc(8'h10, 32'h0f000000, 32'h05000000, "eds_set");
		rc(8'h44, 32'hffffffff, e, "capture0");
		rc(8'h4c, 32'hffffffff, e, "capture2");
		rc(8'h10, 32'h0f000000, 32'h0, "eds_clr");
		wr(8'ha4, e);
		rc(8'h10, 32'h4, 32'h4, "lc_set");
		wr(8'h10, 32'h4);
		rc(8'h10, 32'h4, 32'h0, "lc_clr");
		// second reset in mid-run; pins go idle first, no false edges
		@(posedge mclk);
		ext_dat_pin <= 4'h0;
		ext_load_pin <= 1'b0;
		repeat (8) @(posedge mclk);
		nrst <= 1'b0;
		repeat (2) @(posedge mclk);
		nrst <= 1'b1;
		rc(8'h10, 32'hffffffff, 32'h0, "rst_stat");
		wr(8'h18, 32'h2);
		wr(8'h20, 32'h80330000);
		rtr.send_tc(8'h33, 0);
		rc(8'h10, 32'h3, 32'h2, "sync_cold");
		wr(8'h20, 32'hc0330000);
		rtr.send_tc(8'h33, 0);
		rc(8'h10, 32'h3, 32'h3, "init_sync");
		wr(8'h0c, 32'h400);
		rtr.send_di(6'h1b, 0);
		#1;
		chk("ack", 32'h5b, {25'h0, di_ack_valid_q, di_ack_number_q});
		rc(8'h0c, 32'h3e0, 32'h360, "received_interrupt_number");
		wr(8'h0c, 32'h800);
		rtr.send_di(6'h25, 2);
		#1;
		chk("no_ack", 32'h0, {31'h0, di_ack_valid_q});
		rc(8'h0c, 32'h23e0, 32'h20a0, "received_interrupt_number_wide");
		// initiator: code advances every 4 cycles, so 256 cycles give 64
		wr(8'h18, 32'h1);
		wr(8'h08, 32'h80);
		wr(8'h20, 32'h00050000);
		wr(8'h04, 32'h20000000);
		// look just after the edge, while the pulse stands
		for (i = 0; i < 1100 && tm_event_q !== 1'b1; i++) begin
			@(posedge mclk);
			#1;
		end
		if (i == 1100) begin
			fail_count++;
			close_out();
		end
		chk("tm_code", 32'h5, {24'h0, tc_tx_value_q});
		for (n = 0; n < 3; n++) begin
			d = $random(seed);
			d[21:16] = (n == 0) ? 6'h00 : (n == 1) ? 6'h3f : d[21:16];
			d[12:11] = (n == 2) ? 2'b11 : 2'b00;
			wr(8'h0c, d & 32'h003f181f);
			wr(8'h80, d);
			e = 32'h0;
			for (i = 0; i < 256; i++) begin
				@(posedge mclk);
				#1;
				if (tc_tx_valid_q === 1'b1) begin
					e++;
					chk("ditx", {31'h0, ditx(tc_tx_value_q, d)},
						{31'h0, di_tx_valid_q});
					if (di_tx_valid_q === 1'b1)
						chk("dinum", {26'h0, d[12] & d[11], d[4:0]},
							{26'h0, di_tx_number_q});
				end
			end
			chk("codes", 32'd64, e);
		end
		close_out();
	end
endmodule

`default_nettype wire
